/* rtl/tsw_pkg.sv */
// package of the square-wave timer / event counter: register map, field layout,
// reset values, encodings and the prescaler count.
// assumes a 16-bit register port with 4 address bits and one 125 MHz clock.
package tsw_pkg;

    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 4;

    // register offsets (word index on the register port)
    localparam logic [3:0]  OFS_MODE_CTRL   = 4'h0;
    localparam logic [3:0]  OFS_OUT_CTRL    = 4'h1;
    localparam logic [3:0]  OFS_PRESCALE    = 4'h2;
    localparam logic [3:0]  OFS_CMP_A       = 4'h3;
    localparam logic [3:0]  OFS_CMP_B       = 4'h4;
    localparam logic [3:0]  OFS_COUNTER     = 4'h5;
    localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h6;
    localparam logic [3:0]  OFS_IRQ_MASK    = 4'h7;

    // mode_control_reg fields
    localparam int          MODE_SEL_LO     = 2;
    localparam int          MODE_SEL_HI     = 3;

    // output_control_reg fields
    localparam int          OUT_ENABLE_BIT  = 0;
    localparam int          MATCH_INV_BIT   = 1;
    localparam int          LVL_RESET_BIT   = 2;
    localparam int          LVL_SET_BIT     = 3;
    localparam int          OUT_CTRL_W      = 2;

    // prescaler_mode_reg fields
    localparam int          CLK_SEL_LO      = 0;
    localparam int          CLK_SEL_HI      = 1;
    localparam int          EDGE_SEL_LO     = 4;
    localparam int          EDGE_SEL_HI     = 5;

    // interrupt status / mask bits
    localparam int          IRQ_BIT_A       = 0;
    localparam int          IRQ_BIT_B       = 1;
    localparam int          IRQ_W           = 2;

    // reset values
    localparam logic [1:0]  MODE_RST        = 2'h0;
    localparam logic [1:0]  OUT_CTRL_RST    = 2'h0;
    localparam logic [1:0]  CLK_SEL_RST     = 2'h0;
    localparam logic [1:0]  EDGE_SEL_RST    = 2'h0;
    localparam logic [15:0] CMP_A_RST       = 16'h0000;
    localparam logic [15:0] CMP_B_RST       = 16'h0000;
    localparam logic [15:0] COUNTER_RST     = 16'h0000;
    localparam logic [1:0]  IRQ_MASK_RST    = 2'h3;
    localparam logic [1:0]  IRQ_STATUS_RST  = 2'h0;

    // the prescaler divides the peripheral clock by 256
    localparam int          PRESCALE_DIV    = 256;
    localparam int          PRESCALE_W      = $clog2(PRESCALE_DIV);
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE_DIV - 1);

    typedef enum logic [1:0] {
        TSW_MODE_STOP       = 2'h0,
        TSW_MODE_FREE_A     = 2'h1,
        TSW_MODE_FREE_B     = 2'h2,
        TSW_MODE_MATCH_CLR  = 2'h3
    } tsw_mode_type;

    typedef enum logic [1:0] {
        TSW_CLK_PERIPH      = 2'h0,
        TSW_CLK_DIV256      = 2'h1,
        TSW_CLK_CASCADE     = 2'h2,
        TSW_CLK_EVENT       = 2'h3
    } tsw_clk_sel_type;

    typedef enum logic [1:0] {
        TSW_EDGE_FALL       = 2'h0,
        TSW_EDGE_RISE       = 2'h1,
        TSW_EDGE_NONE       = 2'h2,
        TSW_EDGE_BOTH       = 2'h3
    } tsw_edge_sel_type;

endpackage : tsw_pkg

/* rtl/tsw_edge_if.sv */
// interface between the timer core and its event-pin edge detector.
// assumes both ends run on clk_sys.
`timescale 1ns/10ps
`default_nettype none
interface tsw_edge_if;
    logic [1:0] edge_sel;
    logic       edge_pulse;

    modport det  (input edge_sel, output edge_pulse);
    modport core (output edge_sel, input edge_pulse);
endinterface : tsw_edge_if
`default_nettype wire

/* rtl/tsw_edge_det.sv */
// event pin synchroniser, two-sample noise filter and valid-edge selector.
// assumes the pin is asynchronous to clk_sys; edge_pulse lasts one cycle.
`timescale 1ns/10ps
`default_nettype none
module tsw_edge_det
    import tsw_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic event_input_pin,
    tsw_edge_if.det   edge_port
);

    logic sync_1_r;
    logic sync_2_r;
    logic sample_r;
    logic filt_r;
    logic pulse_r;
    logic rise;
    logic fall;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sync_1_r <= 1'b0;
            sync_2_r <= 1'b0;
        end else begin
            sync_1_r <= event_input_pin;
            sync_2_r <= sync_1_r;
        end
    end

    // a new level is taken only once two successive samples agree
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sample_r <= 1'b0;
            filt_r   <= 1'b0;
        end else begin
            sample_r <= sync_2_r;
            if (sync_2_r == sample_r) begin // R12
                filt_r <= sample_r;
            end
        end
    end

    assign rise = (sync_2_r == sample_r) && sample_r && !filt_r;
    assign fall = (sync_2_r == sample_r) && !sample_r && filt_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pulse_r <= 1'b0;
        end else begin
            case (edge_port.edge_sel) // R16
                TSW_EDGE_FALL: pulse_r <= fall;
                TSW_EDGE_RISE: pulse_r <= rise;
                TSW_EDGE_BOTH: pulse_r <= rise | fall;
                default:       pulse_r <= 1'b0;
            endcase
        end
    end

    assign edge_port.edge_pulse = pulse_r;

endmodule : tsw_edge_det
`default_nettype wire

/* rtl/tsw_timer.sv */
// 16-bit timer / event counter with compare match clear, square-wave output
// and external event counting, reached over a plain register port.
// assumes a single clk_sys domain, synchronous active-low reset, and that
// other_timer_irq comes from logic on clk_sys.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Contract
// (R1) software writes 03H to output control
// (R2) mode 11 starts counting on count clock
// (R3) match A clears counter, irq A, toggles
// (R4) square wave half period is M+1
// (R5) software never loads compare A zero
// (R6) compare B match always raises irq B
// (R7) software masks irq B when unused
// (R8) clock 11 counts event pin edges
// (R9) software avoids event clear-start mode 10
// (R10) first event match after M+2 edges
// (R11) later event matches every M+1 edges
// (R12) event edge needs two agreeing samples
// (R13) counter read never disturbs counting
// (R14) mode 00 stops and clears counter
// (R15) clock select picks the count source
// (R16) edge select picks the valid edge
// (R17) output disabled holds pin low
// (R18) match inversion only when enabled
module tsw_timer
    import tsw_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        event_input_pin,
    input  wire logic        other_timer_irq,
    output logic             timer_output_pin,
    output logic             match_irq_a,
    output logic             match_irq_b,
    output logic             irq
);

    tsw_mode_type             mode_r;
    logic [OUT_CTRL_W-1:0]    out_ctrl_r;
    tsw_clk_sel_type          clk_sel_r;
    tsw_edge_sel_type         edge_sel_r;
    logic [15:0]              compare_reg_a;
    logic [15:0]              compare_reg_b;
    logic [15:0]              up_counter;
    logic                     started_r;
    logic [PRESCALE_W-1:0]    prescale_r;
    logic                     div_pulse;
    logic                     cascade_dly_r;
    logic                     cascade_pulse;
    logic                     count_tick;
    logic                     running;
    logic                     hit_a;
    logic                     hit_b;
    logic                     out_lvl_r;
    logic                     match_a_r;
    logic                     match_b_r;
    logic [IRQ_W-1:0]         sts_r;
    logic [IRQ_W-1:0]         sts_nxt;
    logic [IRQ_W-1:0]         mask_r;
    logic [IRQ_W-1:0]         mask_nxt;
    logic [IRQ_W-1:0]         events;
    logic                     irq_r;
    logic [15:0]              rdata_r;
    logic [15:0]              rd_mux;
    logic                     output_enable_bit;
    logic                     match_invert_enable;
    logic                     wr_mode;
    logic                     wr_out;
    logic                     wr_pre;
    logic                     wr_sts;
    logic                     wr_mask;

    tsw_edge_if edge_bus ();

    tsw_edge_det u_edge_det (
        .clk_sys         (clk_sys),
        .rst_b           (rst_b),
        .event_input_pin (event_input_pin),
        .edge_port       (edge_bus.det)
    );

    assign edge_bus.edge_sel = edge_sel_r;

    assign wr_mode = reg_wr && (reg_addr == OFS_MODE_CTRL);
    assign wr_out  = reg_wr && (reg_addr == OFS_OUT_CTRL);
    assign wr_pre  = reg_wr && (reg_addr == OFS_PRESCALE);
    assign wr_sts  = reg_wr && (reg_addr == OFS_IRQ_STATUS);
    assign wr_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);

    assign output_enable_bit   = out_ctrl_r[OUT_ENABLE_BIT];
    assign match_invert_enable = out_ctrl_r[MATCH_INV_BIT];

    // ---- control registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_r <= TSW_MODE_STOP;
        end else if (wr_mode) begin
            mode_r <= tsw_mode_type'(reg_wdata[MODE_SEL_HI:MODE_SEL_LO]);
        end
    end

    // level set/reset bits are triggers only and are not stored
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            out_ctrl_r <= OUT_CTRL_RST;
        end else if (wr_out) begin
            out_ctrl_r <= reg_wdata[OUT_CTRL_W-1:0]; // R1
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clk_sel_r  <= tsw_clk_sel_type'(CLK_SEL_RST);
            edge_sel_r <= tsw_edge_sel_type'(EDGE_SEL_RST);
        end else if (wr_pre) begin
            clk_sel_r  <= tsw_clk_sel_type'(reg_wdata[CLK_SEL_HI:CLK_SEL_LO]);
            edge_sel_r <= tsw_edge_sel_type'(reg_wdata[EDGE_SEL_HI:EDGE_SEL_LO]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            compare_reg_a <= CMP_A_RST;
            compare_reg_b <= CMP_B_RST;
        end else begin
            if (reg_wr && (reg_addr == OFS_CMP_A)) begin
                compare_reg_a <= reg_wdata;
            end
            if (reg_wr && (reg_addr == OFS_CMP_B)) begin
                compare_reg_b <= reg_wdata;
            end
        end
    end

    // ---- count sources
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prescale_r <= '0;
        end else begin
            prescale_r <= prescale_r + 1'b1;
        end
    end

    assign div_pulse = (prescale_r == PRESCALE_LAST);

    // the other timer's interrupt counts once per rising level
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cascade_dly_r <= 1'b0;
        end else begin
            cascade_dly_r <= other_timer_irq;
        end
    end

    assign cascade_pulse = other_timer_irq && !cascade_dly_r;

    always_comb begin
        case (clk_sel_r) // R15
            TSW_CLK_PERIPH:  count_tick = 1'b1;
            TSW_CLK_DIV256:  count_tick = div_pulse;
            TSW_CLK_CASCADE: count_tick = cascade_pulse;
            TSW_CLK_EVENT:   count_tick = edge_bus.edge_pulse; // R8
            default:         count_tick = 1'b0;
        endcase
    end

    // ---- counter
    assign running = (mode_r != TSW_MODE_STOP);

    // a match is seen on the count clock that leaves the matching value
    assign hit_a = running && started_r && count_tick
                   && (up_counter == compare_reg_a); // R3
    assign hit_b = running && started_r && count_tick
                   && (up_counter == compare_reg_b); // R6

    // the first count clock after start only synchronises, so the first
    // match needs one clock more than every later one
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            started_r <= 1'b0;
        end else if (!running) begin
            started_r <= 1'b0; // R14
        end else if (count_tick) begin
            started_r <= 1'b1; // R2 R10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            up_counter <= COUNTER_RST;
        end else if (!running) begin
            up_counter <= COUNTER_RST; // R14
        end else if (count_tick && started_r) begin
            if (mode_r == TSW_MODE_MATCH_CLR && hit_a) begin
                up_counter <= COUNTER_RST; // R3 R4 R11
            end else begin
                up_counter <= up_counter + 16'h0001;
            end
        end
    end

    // ---- timer output
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            out_lvl_r <= 1'b0;
        end else if (wr_out && !reg_wdata[OUT_ENABLE_BIT]) begin
            out_lvl_r <= 1'b0; // R17
        end else if (!output_enable_bit && !wr_out) begin
            out_lvl_r <= 1'b0; // R17
        end else if (wr_out && reg_wdata[LVL_SET_BIT]) begin
            out_lvl_r <= 1'b1;
        end else if (wr_out && reg_wdata[LVL_RESET_BIT]) begin
            out_lvl_r <= 1'b0;
        end else if (hit_a && mode_r == TSW_MODE_MATCH_CLR && match_invert_enable) begin
            out_lvl_r <= ~out_lvl_r; // R3 R4 R18
        end
    end

    assign timer_output_pin = out_lvl_r;

    // ---- match pulses and interrupt status
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
        end else begin
            match_a_r <= hit_a; // R3
            match_b_r <= hit_b; // R6
        end
    end

    assign match_irq_a = match_a_r;
    assign match_irq_b = match_b_r;

    assign events[IRQ_BIT_A] = hit_a;
    assign events[IRQ_BIT_B] = hit_b;

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        sts_nxt = sts_r;
        if (wr_sts) begin
            sts_nxt = sts_r & ~reg_wdata[IRQ_W-1:0];
        end
        sts_nxt  = sts_nxt | events;
        mask_nxt = wr_mask ? reg_wdata[IRQ_W-1:0] : mask_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sts_r <= IRQ_STATUS_RST;
        end else begin
            sts_r <= sts_nxt;
        end
    end

    // mask bit set means masked; both start masked
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask_r <= IRQ_MASK_RST; // R7
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(sts_nxt & ~mask_nxt);
        end
    end

    assign irq = irq_r;

    // ---- read port: data stand only in the cycle after the strobe
    always_comb begin
        rd_mux = 16'h0000;
        case (reg_addr)
            OFS_MODE_CTRL:  rd_mux[MODE_SEL_HI:MODE_SEL_LO] = mode_r;
            OFS_OUT_CTRL:   rd_mux[OUT_CTRL_W-1:0]          = out_ctrl_r;
            OFS_PRESCALE: begin
                rd_mux[CLK_SEL_HI:CLK_SEL_LO]   = clk_sel_r;
                rd_mux[EDGE_SEL_HI:EDGE_SEL_LO] = edge_sel_r;
            end
            OFS_CMP_A:      rd_mux = compare_reg_a;
            OFS_CMP_B:      rd_mux = compare_reg_b;
            OFS_COUNTER:    rd_mux = up_counter; // R13
            OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = sts_r;
            OFS_IRQ_MASK:   rd_mux[IRQ_W-1:0] = mask_r;
            default:        rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_r;

endmodule : tsw_timer
`default_nettype wire

/* dv/tsw_asserts.sv */
// port checker for the timer: read port, pulses, output level, wave period.
// assumes it is bound into tsw_timer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tsw_asserts
    import tsw_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        timer_output_pin,
    input wire logic        match_irq_a,
    input wire logic        match_irq_b,
    input wire logic        irq
);
    logic [1:0]  mode_r;
    logic [1:0]  csel_r;
    logic [1:0]  octl_r;
    logic [1:0]  mask_r;
    logic [15:0] cmpa_r;
    logic [15:0] gap_r;
    logic        seen_r;
    logic        pin_q_r;
    logic        wr1_r;
    logic        wr2_r;
    logic        tog;
    logic        sq;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    assign tog = timer_output_pin != pin_q_r;
    assign sq  = mode_r == 2'h3 && csel_r == 2'h0 && octl_r == 2'h3;

    // shadow of the written configuration
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_r <= MODE_RST;
            csel_r <= CLK_SEL_RST;
            octl_r <= OUT_CTRL_RST;
            mask_r <= IRQ_MASK_RST;
            cmpa_r <= CMP_A_RST;
        end else if (reg_wr) begin
            if (reg_addr == OFS_MODE_CTRL) mode_r <= reg_wdata[3:2];
            if (reg_addr == OFS_PRESCALE) csel_r <= reg_wdata[1:0];
            if (reg_addr == OFS_OUT_CTRL) octl_r <= reg_wdata[1:0];
            if (reg_addr == OFS_IRQ_MASK) mask_r <= reg_wdata[1:0];
            if (reg_addr == OFS_CMP_A) cmpa_r <= reg_wdata;
        end
    end

    // cycles since the last output toggle, restarted by any write
    always_ff @(posedge clk_sys) begin
        pin_q_r <= timer_output_pin;
        wr1_r   <= reg_wr && rst_b;
        wr2_r   <= wr1_r;
        if (!rst_b || reg_wr) begin
            gap_r  <= 16'h0000;
            seen_r <= 1'b0;
        end else if (tog) begin
            gap_r  <= 16'h0001;
            seen_r <= 1'b1;
        end else begin
            gap_r  <= gap_r + 16'h0001;
        end
    end

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    a_unmapped_read: assert property ($past(reg_rd && reg_addr > 4'h7) |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_irqa_one_cycle: assert property (match_irq_a |=> !match_irq_a)
        else $error("match pulse A too long");
    a_stop_quiet: assert property (mode_r == 2'h0 && $past(mode_r, 2) == 2'h0
        |-> !match_irq_a && !match_irq_b)
        else $error("match while stopped");
    a_out_low: assert property (!octl_r[0] && !wr1_r && !wr2_r |-> !timer_output_pin)
        else $error("output high while disabled");
    a_no_invert: assert property (!octl_r[1] && !wr1_r && !wr2_r
        |-> $stable(timer_output_pin))
        else $error("output moved with inversion off");
    a_square_period: assert property (tog && seen_r && sq
        |-> gap_r == cmpa_r + 16'h0001)
        else $error("square half period wrong");
    a_irqb_level: assert property (match_irq_b && !mask_r[1] |-> ##[0:1] irq)
        else $error("unmasked match B without irq");
    a_all_masked: assert property (mask_r == 2'h3 && !wr1_r && !wr2_r |-> !irq)
        else $error("irq while fully masked");

    c_square: cover property (tog && seen_r && sq);
    c_match_b: cover property (match_irq_b && !mask_r[1]);
    c_event_a: cover property (match_irq_a && csel_r == 2'h3);
endmodule : tsw_asserts

bind tsw_timer tsw_asserts u_tsw_asserts (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .timer_output_pin, .match_irq_a, .match_irq_b, .irq);
`default_nettype wire

/* dv/tsw_pin_model.sv */
// far-side pins: event input and cascade source, driven in pulse trains.
// assumes clk_sys; pins idle low and change just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module tsw_pin_model (
    input  wire logic clk_sys,
    output var logic  event_input_pin,
    output var logic  other_timer_irq
);
    initial begin
        event_input_pin = 1'b0;
        other_timer_irq = 1'b0;
    end

    // hi of 1 on the event pin is a noise spike the filter must drop
    task automatic pulses(input int n, input int hi, input bit casc);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if (casc) other_timer_irq <= 1'b1;
            else event_input_pin <= 1'b1;
            repeat (hi) @(posedge clk_sys);
            other_timer_irq <= 1'b0;
            event_input_pin <= 1'b0;
            repeat (6) @(posedge clk_sys);
        end
    endtask : pulses
endmodule : tsw_pin_model
`default_nettype wire

/* dv/tsw_timer_bench.sv */
// self-checking bench: register calls, pin pulse trains, expected values.
// assumes tsw_timer, tsw_pin_model and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module tsw_timer_bench;
    import tsw_pkg::*;
    logic        clk_sys;
    logic        rst_b;
    logic        reg_wr;
    logic        reg_rd;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [15:0] v;
    logic [15:0] w;
    logic        event_input_pin;
    logic        other_timer_irq;
    logic        timer_output_pin;
    logic        match_irq_a;
    logic        match_irq_b;
    logic        irq;
    logic        p;
    int          n_errors;
    int          cmp_count;
    int          n_irqa;
    int          n0;
    int          t;

    tsw_timer u_tsw_timer (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .event_input_pin, .other_timer_irq, .timer_output_pin,
        .match_irq_a, .match_irq_b, .irq);
    tsw_pin_model u_tsw_pin_model (.clk_sys, .event_input_pin, .other_timer_irq);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // counted on the falling edge, away from the rising-edge reads of n_irqa
    always @(negedge clk_sys) if (match_irq_a === 1'b1) n_irqa++;

    task automatic results();
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd

    task automatic wait_sig(input bit use_irq, output int n);
        logic q;
        q = timer_output_pin;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((use_irq ? irq !== 1'b1 : timer_output_pin === q) && n < 300);
        if (n >= 300) begin
            n_errors++;
            results();
        end
    endtask : wait_sig

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        results();
    end

    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        n_errors = 0;
        cmp_count = 0;
        n_irqa = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // reset values, unmapped place, read-only counter
        rd(OFS_IRQ_MASK, v);
        chk(v, {14'h0000, IRQ_MASK_RST});
        for (int a = 0; a < 9; a++) begin
            if (a != 7) rd(4'(a), v);
            if (a != 7) chk(v, 16'h0000);
        end
        wr(OFS_COUNTER, 16'h0005);
        rd(OFS_COUNTER, v);
        chk(v, 16'h0000);
        // square wave with compare value 4
        wr(OFS_CMP_A, 16'h0004);
        wr(OFS_OUT_CTRL, 16'h0003);
        wr(OFS_MODE_CTRL, 16'h000C);
        wait_sig(1'b0, t);
        wait_sig(1'b0, t);
        chk(16'(t), 16'h0005);
        for (int i = 0; i < 6; i++) begin
            rd(OFS_COUNTER, v);
            chk(16'(v > 16'h0004), 16'h0000);
        end
        rd(OFS_IRQ_STATUS, v);
        // compare B still holds 0, so the cleared count matches it too
        chk(v, 16'h0003);
        chk(16'(irq), 16'h0000);
        wr(OFS_OUT_CTRL, 16'h0001);
        n0 = n_irqa;
        p = timer_output_pin;
        repeat (30) @(posedge clk_sys);
        chk(16'(timer_output_pin), 16'(p));
        chk(16'(n_irqa - n0 > 5), 16'h0001);
        wr(OFS_OUT_CTRL, 16'h0005);
        repeat (2) @(posedge clk_sys);
        chk(16'(timer_output_pin), 16'h0000);
        wr(OFS_OUT_CTRL, 16'h0009);
        repeat (2) @(posedge clk_sys);
        chk(16'(timer_output_pin), 16'h0001);
        wr(OFS_OUT_CTRL, 16'h0002);
        repeat (12) @(posedge clk_sys);
        chk(16'(timer_output_pin), 16'h0000);
        wr(OFS_MODE_CTRL, 16'h0000);
        repeat (20) @(posedge clk_sys);
        rd(OFS_COUNTER, v);
        chk(v, 16'h0000);
        // compare B match, mask, unmask, clear
        wr(OFS_CMP_A, 16'hFFFF);
        wr(OFS_CMP_B, 16'h0030);
        wr(OFS_IRQ_STATUS, 16'h0003);
        wr(OFS_MODE_CTRL, 16'h000C);
        rd(OFS_COUNTER, v);
        rd(OFS_COUNTER, w);
        chk(w, v + 16'h0002);
        repeat (60) @(posedge clk_sys);
        chk(16'(irq), 16'h0000);
        rd(OFS_IRQ_STATUS, v);
        chk(v, 16'h0002);
        wr(OFS_IRQ_MASK, 16'h0001);
        chk(16'(irq), 16'h0001);
        wr(OFS_IRQ_STATUS, 16'h0002);
        chk(16'(irq), 16'h0000);
        wr(OFS_MODE_CTRL, 16'h0000);
        wr(OFS_MODE_CTRL, 16'h000C);
        wait_sig(1'b1, t);
        chk(16'(irq), 16'h0001);
        wr(OFS_IRQ_MASK, 16'h0003);
        wr(OFS_MODE_CTRL, 16'h0000);
        // prescaled clock, cascade source
        wr(OFS_PRESCALE, 16'h0001);
        wr(OFS_MODE_CTRL, 16'h000C);
        repeat (1024) @(posedge clk_sys);
        rd(OFS_COUNTER, v);
        chk(16'(v >= 16'h0002 && v <= 16'h0004), 16'h0001);
        wr(OFS_MODE_CTRL, 16'h0000);
        wr(OFS_PRESCALE, 16'h0002);
        wr(OFS_MODE_CTRL, 16'h000C);
        u_tsw_pin_model.pulses(4, 1, 1'b1);
        rd(OFS_COUNTER, v);
        chk(v, 16'h0003);
        // event edges for falling, rising, both; spikes dropped
        for (int s = 0; s < 4; s++) begin
            if (s == 2) continue;
            wr(OFS_MODE_CTRL, 16'h0000);
            wr(OFS_PRESCALE, 16'(s * 16 + 3));
            wr(OFS_MODE_CTRL, 16'h000C);
            u_tsw_pin_model.pulses(2, 1, 1'b0);
            u_tsw_pin_model.pulses(5, 6, 1'b0);
            rd(OFS_COUNTER, v);
            chk(v, (s == 3) ? 16'h0009 : 16'h0004);
        end
        // event matches with compare value 3
        wr(OFS_MODE_CTRL, 16'h0000);
        wr(OFS_PRESCALE, 16'h0013);
        wr(OFS_CMP_A, 16'h0003);
        wr(OFS_MODE_CTRL, 16'h000C);
        n0 = n_irqa;
        u_tsw_pin_model.pulses(4, 6, 1'b0);
        chk(16'(n_irqa - n0), 16'h0000);
        u_tsw_pin_model.pulses(1, 6, 1'b0);
        chk(16'(n_irqa - n0), 16'h0001);
        u_tsw_pin_model.pulses(3, 6, 1'b0);
        chk(16'(n_irqa - n0), 16'h0001);
        u_tsw_pin_model.pulses(1, 6, 1'b0);
        chk(16'(n_irqa - n0), 16'h0002);
        results();
    end
endmodule : tsw_timer_bench
`default_nettype wire
